/* design/tsc_pkg.sv */
// ============================================================
// Slave-mode and trigger control constants for the 16-bit timer
// ============================================================
// Holds register map, field positions, mode codes and bus answers.
// Assumes a 32-bit AXI4-Lite register bus on the timer kernel clock.
package tsc_pkg;
   localparam logic [7:0]  SMC_OFFSET    = 8'h08;
   localparam logic [7:0]  STAT_OFFSET   = 8'h40;
   localparam logic [15:0] SMC_RESET     = 16'h0000;
   localparam int          SMF_LSB       = 0;
   localparam int          REFCLR_BIT    = 3;
   localparam int          TRGSRC_LSB    = 4;
   localparam int          MSM_BIT       = 7;
   localparam int          FILT_LSB      = 8;
   localparam int          PSC_LSB       = 12;
   localparam int          ECLK2_BIT     = 14;
   localparam int          POL_BIT       = 15;
   localparam logic [2:0]  SMF_OFF       = 3'h0;
   localparam logic [2:0]  SMF_ENC1      = 3'h1;
   localparam logic [2:0]  SMF_ENC2      = 3'h2;
   localparam logic [2:0]  SMF_ENC3      = 3'h3;
   localparam logic [2:0]  SMF_RESET     = 3'h4;
   localparam logic [2:0]  SMF_GATED     = 3'h5;
   localparam logic [2:0]  SMF_TRIGGER   = 3'h6;
   localparam logic [2:0]  SMF_EXTCLK1   = 3'h7;
   localparam logic [2:0]  TRG_CH1EDGE   = 3'h4;
   localparam logic [2:0]  TRG_CH1       = 3'h5;
   localparam logic [2:0]  TRG_CH2       = 3'h6;
   localparam logic [2:0]  TRG_EXT_TRIGGER_FILTERED      = 3'h7;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* design/tsc_slave_ctrl.sv */
// ============================================================
// Timer slave-mode and trigger-input controller
// ============================================================
// Picks the trigger input, conditions the external trigger and
// turns the selected slave function into counter controls.
// Assumes channel inputs, internal triggers and run enable come from
// logic on clk; only the external trigger pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module tsc_slave_ctrl
   import tsc_pkg::*;
#(
   parameter int INSTANCE = 2
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        extTriggerPin,
   input  wire logic        ch1FilteredInput,
   input  wire logic        ch2FilteredInput,
   input  wire logic [15:0] timerTrigger,
   input  wire logic        refClearInput,
   input  wire logic        counterRunEnable,
   input  wire logic [1:0]  filterClockDivide,
   output var  logic        countTick,
   output var  logic        countUp,
   output var  logic        counterReset,
   output var  logic        updateEvent,
   output var  logic        counterStart,
   output var  logic        gateRun,
   output var  logic        refClearOut,
   output var  logic        syncMasterSlave,
   output var  logic        triggerInput,
   output var  logic        extTriggerFiltered
);

   typedef struct packed {
      logic [15:0] smc;
      logic        awReady;
      logic        wReady;
      logic        awHave;
      logic        wHave;
      logic [7:0]  awAddr;
      logic [15:0] wData;
      logic [1:0]  wStrb;
      logic        bValid;
      logic [1:0]  bResp;
      logic        arReady;
      logic        rValid;
      logic [1:0]  rResp;
      logic [31:0] rData;
      logic        etrMeta;
      logic        etrSync;
      logic        etrPolPrev;
      logic [2:0]  etrEdgeCnt;
      logic        ext_trigger_prescaled;
      logic [1:0]  dtsCnt;
      logic [4:0]  divCnt;
      logic [3:0]  agreeCnt;
      logic        ext_trigger_filtered;
      logic        etrfPrev;
      logic        ch1Prev;
      logic        ch2Prev;
      logic        trigger_input;
      logic        trgiPrev;
      logic        countTick;
      logic        countUp;
      logic        counterReset;
      logic        updateEvent;
      logic        counterStart;
      logic        gateRun;
      logic        refClear;
      logic        msm;
   } tsc_state_s;

   tsc_state_s s_reg;
   tsc_state_s s_next;

   // ============================================================
   // Decoding helpers
   // ============================================================
   function automatic logic [2:0] filt_div_log2(input logic [3:0] code);
      unique case (code)
         4'h0, 4'h1, 4'h2, 4'h3: filt_div_log2 = 3'h0;
         4'h4, 4'h5:             filt_div_log2 = 3'h1;
         4'h6, 4'h7:             filt_div_log2 = 3'h2;
         4'h8, 4'h9:             filt_div_log2 = 3'h3;
         4'hA, 4'hB:             filt_div_log2 = 3'h4;
         4'hC, 4'hD, 4'hE, 4'hF: filt_div_log2 = 3'h5;
      endcase
   endfunction

   function automatic logic [3:0] filt_len(input logic [3:0] code);
      unique case (code)
         4'h0:                   filt_len = 4'h1;
         4'h1:                   filt_len = 4'h2;
         4'h2:                   filt_len = 4'h4;
         4'h4, 4'h6, 4'h8:       filt_len = 4'h6;
         4'hA, 4'hC, 4'hD:       filt_len = 4'h5;
         4'h3, 4'h5, 4'h7, 4'h9,
         4'hB, 4'hE, 4'hF:       filt_len = 4'h8;
      endcase
   endfunction

   // Instance number feeding each internal trigger of this timer
   function automatic logic [3:0] itr_source(input logic [1:0] idx);
      logic [3:0] src;
      src = 4'h1;
      if (INSTANCE == 3) begin
         unique case (idx)
            2'h0: src = 4'h1;
            2'h1: src = 4'h2;
            2'h2: src = 4'hF;
            2'h3: src = 4'hE;
         endcase
      end else begin
         unique case (idx)
            2'h0: src = 4'h1;
            2'h1: src = 4'hF;
            2'h2: src = 4'h3;
            2'h3: src = 4'hE;
         endcase
      end
      return src;
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr == SMC_OFFSET) || (addr == STAT_OFFSET);
   endfunction

   // ============================================================
   // Combinational next state
   // ============================================================
   logic [2:0]  smf;
   logic [2:0]  trigger_source_select;
   logic [3:0]  filtCode;
   logic [1:0]  pscCode;
   logic        eclk2;
   logic        etrPol;
   logic        dtsTick;
   logic        sampleEn;
   logic [4:0]  divLast;
   logic        ch1Edge;
   logic        ch2Edge;
   logic        trgiRise;
   logic        etrfRise;
   logic        extTick;
   logic [15:0] wrVal;
   logic        wrFire;

   always_comb begin
      s_next   = s_reg;
      smf      = s_reg.smc[SMF_LSB +: 3];
      trigger_source_select   = s_reg.smc[TRGSRC_LSB +: 3];
      filtCode = s_reg.smc[FILT_LSB +: 4];
      pscCode  = s_reg.smc[PSC_LSB +: 2];
      eclk2    = s_reg.smc[ECLK2_BIT];

      // Register bus: address and data taken in either order
      s_next.updateEvent = 1'b0;
      if (s_axi_awvalid && s_reg.awReady) begin
         s_next.awHave = 1'b1;
         s_next.awAddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_reg.wReady) begin
         s_next.wHave = 1'b1;
         s_next.wData = s_axi_wdata[15:0];
         s_next.wStrb = s_axi_wstrb[1:0];
      end
      wrFire = s_reg.awHave && s_reg.wHave && !s_reg.bValid;
      wrVal  = s_reg.smc;
      if (s_reg.wStrb[0]) begin
         wrVal[7:0] = s_reg.wData[7:0];
      end
      if (s_reg.wStrb[1]) begin
         wrVal[15:8] = s_reg.wData[15:8];
      end
      if (wrFire) begin
         s_next.awHave = 1'b0;
         s_next.wHave  = 1'b0;
         s_next.bValid = 1'b1;
         s_next.bResp  = is_mapped(s_reg.awAddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_reg.awAddr == SMC_OFFSET) begin
            s_next.smc = wrVal;
         end
      end else if (s_reg.bValid && s_axi_bready) begin
         s_next.bValid = 1'b0;
      end
      s_next.awReady = !s_next.awHave && !s_next.bValid;
      s_next.wReady  = !s_next.wHave && !s_next.bValid;

      if (s_axi_arvalid && s_reg.arReady) begin
         s_next.rValid = 1'b1;
         s_next.rResp  = is_mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
         s_next.rData  = 32'h0000_0000;
         if (s_axi_araddr[7:0] == SMC_OFFSET) begin
            s_next.rData[15:0] = s_reg.smc;
         end else if (s_axi_araddr[7:0] == STAT_OFFSET) begin
            s_next.rData[4:0] = {s_reg.countUp, s_reg.gateRun, s_reg.ext_trigger_prescaled,
                                 s_reg.ext_trigger_filtered, s_reg.trigger_input};
         end
      end else if (s_reg.rValid && s_axi_rready) begin
         s_next.rValid = 1'b0;
      end
      s_next.arReady = !s_next.rValid;

      // External trigger: sync, polarity, prescale, filter
      s_next.etrMeta    = extTriggerPin;
      s_next.etrSync    = s_reg.etrMeta;
      etrPol            = s_reg.etrSync ^ s_reg.smc[POL_BIT];
      s_next.etrPolPrev = etrPol;
      if (etrPol && !s_reg.etrPolPrev) begin
         s_next.etrEdgeCnt = s_reg.etrEdgeCnt + 3'h1;
      end
      // Divide by 2^k taken from edge count bit k-1
      s_next.ext_trigger_prescaled = (pscCode == 2'h0) ? etrPol : s_reg.etrEdgeCnt[pscCode - 2'h1];

      // DTS tick: reserved divide code behaves as divide by one
      dtsTick = 1'b1;
      s_next.dtsCnt = 2'h0;
      if (filterClockDivide == 2'h1 || filterClockDivide == 2'h2) begin
         dtsTick       = (s_reg.dtsCnt == ((2'h1 << filterClockDivide) - 2'h1));
         s_next.dtsCnt = dtsTick ? 2'h0 : s_reg.dtsCnt + 2'h1;
      end

      divLast = 5'((6'h1 << filt_div_log2(filtCode)) - 6'h1);
      if (filtCode == 4'h0) begin
         sampleEn = dtsTick;
         s_next.divCnt = 5'h00;
      end else begin
         sampleEn = (s_reg.divCnt >= divLast);
         s_next.divCnt = sampleEn ? 5'h00 : s_reg.divCnt + 5'h01;
      end
      if (sampleEn) begin
         if (s_reg.ext_trigger_prescaled == s_reg.ext_trigger_filtered) begin
            s_next.agreeCnt = 4'h0;
         end else if (s_reg.agreeCnt + 4'h1 >= filt_len(filtCode)) begin
            s_next.ext_trigger_filtered     = s_reg.ext_trigger_prescaled;
            s_next.agreeCnt = 4'h0;
         end else begin
            s_next.agreeCnt = s_reg.agreeCnt + 4'h1;
         end
      end
      s_next.etrfPrev = s_reg.ext_trigger_filtered;
      etrfRise        = s_reg.ext_trigger_filtered && !s_reg.etrfPrev;

      // Channel edges and trigger selection, all on clk
      s_next.ch1Prev = ch1FilteredInput;
      s_next.ch2Prev = ch2FilteredInput;
      ch1Edge = ch1FilteredInput ^ s_reg.ch1Prev;
      ch2Edge = ch2FilteredInput ^ s_reg.ch2Prev;
      unique case (trigger_source_select)
         TRG_CH1EDGE: s_next.trigger_input = ch1Edge;
         TRG_CH1:     s_next.trigger_input = ch1FilteredInput;
         TRG_CH2:     s_next.trigger_input = ch2FilteredInput;
         TRG_EXT_TRIGGER_FILTERED:    s_next.trigger_input = s_reg.ext_trigger_filtered;
         default:     s_next.trigger_input = timerTrigger[itr_source(trigger_source_select[1:0])];
      endcase
      s_next.trgiPrev = s_reg.trigger_input;
      trgiRise        = s_reg.trigger_input && !s_reg.trgiPrev;

      // Slave functions
      extTick = eclk2 ? etrfRise : 1'b1;
      s_next.counterReset = 1'b0;
      s_next.counterStart = 1'b0;
      s_next.gateRun      = 1'b1;
      s_next.countTick    = counterRunEnable && extTick;
      unique case (smf)
         SMF_OFF: begin
         end
         SMF_ENC1: begin
            s_next.countTick = counterRunEnable && ch2Edge;
            if (ch2Edge) begin
               s_next.countUp = !(ch2FilteredInput ^ ch1FilteredInput);
            end
         end
         SMF_ENC2: begin
            s_next.countTick = counterRunEnable && ch1Edge;
            if (ch1Edge) begin
               s_next.countUp = ch1FilteredInput ^ ch2FilteredInput;
            end
         end
         SMF_ENC3: begin
            s_next.countTick = counterRunEnable && (ch1Edge || ch2Edge);
            if (ch1Edge) begin
               s_next.countUp = ch1FilteredInput ^ ch2FilteredInput;
            end else if (ch2Edge) begin
               s_next.countUp = !(ch2FilteredInput ^ ch1FilteredInput);
            end
         end
         SMF_RESET: begin
            s_next.counterReset = trgiRise;
            s_next.updateEvent  = trgiRise;
         end
         SMF_GATED: begin
            // Low gate only holds the count, it never clears it
            s_next.gateRun   = s_reg.trigger_input;
            s_next.countTick = counterRunEnable && extTick && s_reg.trigger_input;
         end
         SMF_TRIGGER: begin
            s_next.counterStart = trgiRise;
         end
         SMF_EXTCLK1: begin
            // With clock mode 2 also set the filtered trigger wins
            s_next.countTick = counterRunEnable && (eclk2 ? etrfRise : trgiRise);
         end
      endcase
      // Direction is only meaningful in the encoder modes; elsewhere count up
      if (smf == SMF_OFF || smf[2]) begin
         s_next.countUp = 1'b1;
      end

      s_next.refClear = s_reg.smc[REFCLR_BIT] ? s_reg.ext_trigger_filtered : refClearInput;
      s_next.msm      = s_reg.smc[MSM_BIT];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg         <= '0;
         s_reg.smc     <= SMC_RESET;
         s_reg.countUp <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ============================================================
   // Outputs, all straight from the state flops
   // ============================================================
   assign s_axi_awready      = s_reg.awReady;
   assign s_axi_wready       = s_reg.wReady;
   assign s_axi_bvalid       = s_reg.bValid;
   assign s_axi_bresp        = s_reg.bResp;
   assign s_axi_arready      = s_reg.arReady;
   assign s_axi_rvalid       = s_reg.rValid;
   assign s_axi_rresp        = s_reg.rResp;
   assign s_axi_rdata        = s_reg.rData;
   assign countTick          = s_reg.countTick;
   assign countUp            = s_reg.countUp;
   assign counterReset       = s_reg.counterReset;
   assign updateEvent        = s_reg.updateEvent;
   assign counterStart       = s_reg.counterStart;
   assign gateRun            = s_reg.gateRun;
   assign refClearOut        = s_reg.refClear;
   assign syncMasterSlave    = s_reg.msm;
   assign triggerInput       = s_reg.trigger_input;
   assign extTriggerFiltered = s_reg.ext_trigger_filtered;

   // ============================================================
   // Assertions
   // ============================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence trig_rise_s;
      trgiRise && smf == SMF_RESET;
   endsequence
   sequence reset_pulse_s;
      counterReset && updateEvent ##1 !counterReset;
   endsequence

   reset_mode_a: assert property (trig_rise_s |=> reset_pulse_s)
      else $error("reset mode missed trigger edge");
   gated_noreset_a: assert property (smf == SMF_GATED |=> !counterReset)
      else $error("gated mode reset the counter");
   gate_hold_a: assert property (smf == SMF_GATED && !s_reg.trigger_input |=> !countTick)
      else $error("count while gate low");
   trigger_start_a: assert property (trgiRise && smf == SMF_TRIGGER |=> counterStart)
      else $error("trigger mode did not start");
   extclk_tick_a: assert property (smf == SMF_EXTCLK1 && !eclk2 && counterRunEnable
                                   |=> countTick == $past(trgiRise))
      else $error("external clock tick wrong");
   both_clk_a: assert property (smf == SMF_EXTCLK1 && eclk2 && counterRunEnable
                                |=> countTick == $past(etrfRise))
      else $error("clock 2 not taking over");
   off_tick_a: assert property (smf == SMF_OFF && !eclk2 |=> countTick == $past(counterRunEnable))
      else $error("internal clock tick wrong");
   enc1_tick_a: assert property (smf == SMF_ENC1 && counterRunEnable && !ch2Edge
                                 |=> !countTick)
      else $error("encoder 1 counted without edge");
   ref_clear_a: assert property (s_reg.smc[REFCLR_BIT]
                                 |=> refClearOut == $past(s_reg.ext_trigger_filtered))
      else $error("reference clear source wrong");
   filt_hold_a: assert property (!sampleEn |=> $stable(s_reg.ext_trigger_filtered))
      else $error("filter moved between samples");
   psc_pass_a: assert property (pscCode == 2'h0 |=> s_reg.ext_trigger_prescaled == $past(etrPol))
      else $error("undivided trigger not passed");
   msm_a: assert property (##1 syncMasterSlave == $past(s_reg.smc[MSM_BIT]))
      else $error("sync enable not following bit");
   write_answer_a: assert property (wrFire |=> s_axi_bvalid && !s_axi_awready)
      else $error("write not answered");

endmodule
`default_nettype wire

/* tb/tsc_far_model.sv */
// Far side of the slave controller: other timer instances and channel sources.
// Assumes the bench sets the levels; outputs change on clk like real logic.
`timescale 1ns/10ps
`default_nettype none
module tsc_far_model (
   input  wire logic        clk,
   input  wire logic [3:0]  trgIdx,
   input  wire logic        trgLvl,
   input  wire logic        ch1Lvl,
   input  wire logic        ch2Lvl,
   input  wire logic        extLvl,
   output var  logic [15:0] timerTrigger,
   output var  logic        ch1FilteredInput,
   output var  logic        ch2FilteredInput,
   output var  logic        extTriggerPin
);
   // Only the chosen instance raises its trigger, so a wrong route reads low
   always_ff @(posedge clk) begin
      timerTrigger <= trgLvl ? (16'h0001 << trgIdx) : 16'h0000;
      ch1FilteredInput <= ch1Lvl;
      ch2FilteredInput <= ch2Lvl;
      extTriggerPin <= extLvl;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the timer slave-mode and trigger controller.
// Assumes the package constants and a far-side model on the same clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import tsc_pkg::*;
   logic        clk = 1'b0, reset = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF, trgIdx = 4'h0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, filterClockDivide = 2'h0;
   logic [31:0] s_axi_rdata;
   logic [15:0] timerTrigger;
   logic        extTriggerPin, ch1FilteredInput, ch2FilteredInput;
   logic        refClearInput = 0, counterRunEnable = 1;
   logic        countTick, countUp, counterReset, updateEvent, counterStart, gateRun;
   logic        refClearOut, syncMasterSlave, triggerInput, extTriggerFiltered;
   logic        trgLvl = 0, ch1Lvl = 0, ch2Lvl = 0, extLvl = 0;
   int          n_mismatch = 0, comparisons = 0, nTick = 0, nRst = 0, nStart = 0;
   logic [3:0]  itrMap [4] = '{4'h1, 4'hF, 4'h3, 4'hE};

   always #5 clk = ~clk;
   // Counted on the falling edge so that zero at a rising edge never races it
   always @(negedge clk) begin
      if (countTick === 1'b1) nTick++;
      if (counterReset === 1'b1 && updateEvent === 1'b1) nRst++;
      if (counterStart === 1'b1) nStart++;
   end

   tsc_slave_ctrl #(.INSTANCE(2)) i_tsc_slave_ctrl (.clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .extTriggerPin, .ch1FilteredInput, .ch2FilteredInput,
      .timerTrigger, .refClearInput, .counterRunEnable, .filterClockDivide,
      .countTick, .countUp, .counterReset, .updateEvent, .counterStart, .gateRun,
      .refClearOut, .syncMasterSlave, .triggerInput, .extTriggerFiltered);
   tsc_far_model i_tsc_far_model (.clk, .trgIdx, .trgLvl, .ch1Lvl, .ch2Lvl, .extLvl,
      .timerTrigger, .ch1FilteredInput, .ch2FilteredInput, .extTriggerPin);

   // ============================================================
   // Shared tasks
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e, input string m);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task limit(input int n);
      if (n >= 50) begin
         n_mismatch++;
         $display("BAD %0t bus timeout", $time);
         close_out;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task zero;
      nTick = 0;
      nRst = 0;
      nStart = 0;
   endtask
   task axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid && n < 50);
      limit(n);
      chk(s_axi_bresp, er, "write response");
      s_axi_bready <= 0;
   endtask
   task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid && n < 50);
      limit(n);
      chk(s_axi_rdata, ed, "read data");
      chk(s_axi_rresp, er, "read response");
      s_axi_rready <= 0;
   endtask
   // Source goes in with the slave function off first, to avoid false edges
   task cfg(input logic [2:0] src, input logic [2:0] mode, input logic [15:0] hi);
      axw(SMC_OFFSET, hi | {9'h0, src, 4'h0}, RESP_OKAY);
      axw(SMC_OFFSET, hi | {9'h0, src, 1'b0, mode}, RESP_OKAY);
      cyc(2);
   endtask
   task trg_pulse;
      trgLvl <= 1;
      cyc(6);
      trgLvl <= 0;
      cyc(6);
   endtask
   // Slow enough that the prescaled trigger stays under a quarter of clk
   task ext_pulse(input int w);
      extLvl <= 1;
      cyc(w);
      extLvl <= 0;
      cyc(w);
   endtask

   // ============================================================
   // Scenarios
   task t_regs;
      axr(SMC_OFFSET, 32'h0, RESP_OKAY);
      axw(SMC_OFFSET, 16'hC3A0, RESP_OKAY);
      axr(SMC_OFFSET, 32'h0000C3A0, RESP_OKAY);
      axw(8'h20, 16'h1234, RESP_SLVERR);
      axr(8'h20, 32'h0, RESP_SLVERR);
      axw(SMC_OFFSET, 16'h0, RESP_OKAY);
      $display("test regs done");
   endtask
   task t_src;
      for (int k = 0; k < 4; k++) begin
         cfg(k[2:0], SMF_OFF, 16'h0);
         trgIdx <= itrMap[(k + 1) % 4];
         trgLvl <= 1;
         cyc(6);
         chk(triggerInput, 1'b0, "foreign trigger");
         trgIdx <= itrMap[k];
         cyc(6);
         chk(triggerInput, 1'b1, "internal trigger");
         trgLvl <= 0;
      end
      cfg(TRG_CH1, SMF_OFF, 16'h0);
      ch1Lvl <= 1;
      cyc(6);
      chk(triggerInput, 1'b1, "ch1 source");
      ch1Lvl <= 0;
      cfg(TRG_CH2, SMF_OFF, 16'h0);
      ch2Lvl <= 1;
      cyc(6);
      chk(triggerInput, 1'b1, "ch2 source");
      ch2Lvl <= 0;
      $display("test sources done");
   endtask
   task t_modes;
      trgIdx <= 4'h1;
      cfg(3'h0, SMF_OFF, 16'h0);
      zero;
      cyc(10);
      chk(nTick, 10, "internal tick");
      cfg(3'h0, SMF_RESET, 16'h0);
      zero;
      trg_pulse;
      chk(nRst, 1, "reset pulse");
      cfg(3'h0, SMF_TRIGGER, 16'h0);
      zero;
      trg_pulse;
      chk(nStart, 1, "start pulse");
      chk(nRst, 0, "trigger mode no reset");
      cfg(3'h0, SMF_EXTCLK1, 16'h0);
      zero;
      repeat (3) trg_pulse;
      chk(nTick, 3, "external clock one");
      cfg(3'h0, SMF_GATED, 16'h0);
      zero;
      trgLvl <= 1;
      cyc(6);
      chk(gateRun, 1'b1, "gate open");
      trgLvl <= 0;
      cyc(6);
      chk(gateRun, 1'b0, "gate shut");
      trgLvl <= 1;
      cyc(6);
      chk(gateRun, 1'b1, "gate resumes");
      chk(nRst, 0, "gate never resets");
      trgLvl <= 0;
      cfg(TRG_CH1EDGE, SMF_RESET, 16'h0);
      zero;
      ch1Lvl <= 1;
      cyc(6);
      ch1Lvl <= 0;
      cyc(6);
      chk(nRst, 2, "ch1 edge detector");
      $display("test modes done");
   endtask
   task enc_step(input logic a, input logic b);
      ch1Lvl <= a;
      ch2Lvl <= b;
      cyc(5);
   endtask
   // One quadrature cycle: ch1 leading counts up, ch2 leading counts down
   task t_enc;
      for (int m = 1; m < 4; m++) begin
         for (int d = 0; d < 2; d++) begin
            cfg(3'h0, m[2:0], 16'h0);
            zero;
            if (d == 0) begin
               enc_step(1'b1, 1'b0);
               enc_step(1'b1, 1'b1);
               enc_step(1'b0, 1'b1);
            end else begin
               enc_step(1'b0, 1'b1);
               enc_step(1'b1, 1'b1);
               enc_step(1'b1, 1'b0);
            end
            enc_step(1'b0, 1'b0);
            chk(nTick, (m == 3) ? 4 : 2, "encoder edges");
            chk(countUp, (d == 0) ? 1 : 0, "encoder direction");
         end
      end
      $display("test encoder done");
   endtask
   task t_filt(input logic [3:0] c, input int s, input int l);
      cfg(3'h0, SMF_OFF, {4'h4, c, 8'h0});
      cyc(10);
      zero;
      ext_pulse(s);
      chk(nTick, 0, "short pulse kept out");
      ext_pulse(l);
      chk(nTick, 1, "long pulse passed");
   endtask
   task t_ext;
      refClearInput <= 1;
      axw(SMC_OFFSET, 16'h0088, RESP_OKAY);
      cyc(10);
      chk(extTriggerFiltered, 1'b0, "ext idle");
      chk(refClearOut, 1'b0, "clear from ext");
      chk(syncMasterSlave, 1'b1, "sync on");
      refClearInput <= 0;
      axw(SMC_OFFSET, 16'h8000, RESP_OKAY);
      cyc(10);
      chk(extTriggerFiltered, 1'b1, "ext inverted");
      chk(refClearOut, 1'b0, "clear from input");
      chk(syncMasterSlave, 1'b0, "sync off");
      for (int p = 0; p < 4; p++) begin
         cfg(3'h0, SMF_OFF, {2'b01, p[1:0], 12'h0});
         cyc(10);
         zero;
         repeat (8) ext_pulse(6);
         chk(nTick, 8 >> p, "prescaled clock two");
      end
      t_filt(4'h3, 6, 12);
      t_filt(4'h4, 8, 20);
      cfg(3'h0, SMF_EXTCLK1, 16'h4000);
      zero;
      trg_pulse;
      ext_pulse(6);
      chk(nTick, 1, "both clocks use ext");
      $display("test external done");
   endtask

   // ============================================================
   // Main sequence
   initial begin
      cyc(4);
      reset <= 0;
      t_regs;
      t_src;
      t_modes;
      t_enc;
      t_ext;
      close_out;
   end
endmodule
`default_nettype wire
